// file: inc/loop_select_regs.svh
// register indices, reset values, field positions and codes of the reference selector
`ifndef LOOP_SELECT_REGS_SVH
`define LOOP_SELECT_REGS_SVH

`define IDX_RANK_SECOND_PAIR 8'h31
`define IDX_RANK_FIRST_PAIR  8'h32
`define IDX_MODE_SELECTION   8'h33

`define RST_RANK_SECOND_PAIR 8'h32
`define RST_RANK_FIRST_PAIR  8'h10
`define RST_MODE_SELECTION   8'h03

`define RANK_LO_MSB 2
`define RANK_LO_LSB 0
`define RANK_HI_MSB 6
`define RANK_HI_LSB 4
`define MODE_MSB 1
`define MODE_LSB 0
`define EXTFB_BIT 5
`define CHOICE_MSB 7
`define CHOICE_LSB 6

`define RANK_DISABLED 3'h7
`define RANK_MAX_LEGAL 3'h6

`define MODE_FREERUN  2'h0
`define MODE_HOLDOVER 2'h1
`define MODE_FORCED   2'h2
`define MODE_AUTO     2'h3

`endif

// file: inc/loop_select_pkg.sv
// types shared by the reference selector modules
package loop_select_pkg;
    typedef enum logic [2:0] {
        ST_FREERUN  = 3'h1,
        ST_HOLDOVER = 3'h2,
        ST_LOCKED   = 3'h4
    } loop_state_t;
    typedef logic [1:0] ref_index_t;
    typedef logic [2:0] rank_t;
endpackage

// file: verilog/ref_rank_finder.sv
// finds the best eligible reference by rank, lowest index winning a tie
`include "loop_select_regs.svh"
module ref_rank_finder
    import loop_select_pkg::*;
#(
    parameter int REFS = 4
) (
    input wire logic [REFS*3-1:0] ranks,
    input wire logic [REFS-1:0] available,
    output logic [REFS-1:0] eligible,
    output logic anyEligible,
    output logic [1:0] bestIdx,
    output logic [2:0] bestRank
);
    if (REFS != 4) begin : g_check
        $error("ref_rank_finder serves exactly four references");
    end

    genvar g;
    for (g = 0; g < REFS; g++) begin : g_elig
        // code 110 stays eligible as the lowest rank; only 111 disables
        assign eligible[g] = available[g] && (ranks[g*3 +: 3] != `RANK_DISABLED);
    end

    always_comb begin
        anyEligible = 1'b0;
        bestIdx = 2'h0;
        bestRank = `RANK_DISABLED;
        // strict compare keeps the lowest index among equal ranks
        for (int i = 0; i < REFS; i++) begin
            if (eligible[i] && (!anyEligible || ranks[i*3 +: 3] < bestRank)) begin
                anyEligible = 1'b1;
                bestIdx = 2'(i);
                bestRank = ranks[i*3 +: 3];
            end
        end
    end
endmodule

// file: verilog/loop_mode_fsm.sv
// freerun, holdover and locked state of the loop
`include "loop_select_regs.svh"
module loop_mode_fsm
    import loop_select_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [1:0] mode,
    input wire logic refUsable,
    output loop_state_t state
);
    loop_state_t next_state;

    always_comb begin
        case (mode)
            `MODE_FREERUN: next_state = ST_FREERUN;
            `MODE_HOLDOVER: next_state = ST_HOLDOVER;
            `MODE_FORCED, `MODE_AUTO: next_state = refUsable ? ST_LOCKED : ST_HOLDOVER;
            default: next_state = ST_FREERUN;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= ST_FREERUN;
        end else begin
            state <= next_state;
        end
    end
endmodule

// file: verilog/dpll_reference_priority_select.sv
// apb registers and automatic reference choice for loop zero
//
// Chosen here: the APB register port.
`include "loop_select_regs.svh"
module dpll_reference_priority_select
    import loop_select_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] refAvailable,
    output logic [1:0] selectedRef,
    output logic loopLocked,
    output logic loopHoldover,
    output logic loopFreerun,
    output logic extFeedbackEnable
);
    logic [7:0] rankSecondPair;
    logic [7:0] rankFirstPair;
    logic [1:0] loopZeroOperatingMode;
    logic [1:0] choiceControl;
    logic extFb;
    logic answerFlag;
    logic [31:0] readData;
    logic errFlag;
    loop_state_t loopState;
    // a literal cannot be part-selected, so the reset word is named first
    localparam logic [7:0] MODE_RESET = `RST_MODE_SELECTION;

    // decode
    wire [11:0] addrSecond = {2'h0, `IDX_RANK_SECOND_PAIR, 2'h0};
    wire [11:0] addrFirst = {2'h0, `IDX_RANK_FIRST_PAIR, 2'h0};
    wire [11:0] addrMode = {2'h0, `IDX_MODE_SELECTION, 2'h0};
    wire hitSecond = (paddr == addrSecond);
    wire hitFirst = (paddr == addrFirst);
    wire hitMode = (paddr == addrMode);
    wire hitAny = hitSecond || hitFirst || hitMode;
    // one wait state lets read data come from a flip-flop
    wire accessFirst = psel && penable && !answerFlag;
    wire commit = psel && penable && answerFlag;
    wire regWrite = commit && pwrite && hitAny;

    rank_t loopZeroFirstInputRank;
    rank_t loopZeroSecondInputRank;
    rank_t loopZeroThirdInputRank;
    rank_t loopZeroFourthInputRank;
    assign loopZeroFirstInputRank = rankFirstPair[`RANK_LO_MSB:`RANK_LO_LSB];
    assign loopZeroSecondInputRank = rankFirstPair[`RANK_HI_MSB:`RANK_HI_LSB];
    assign loopZeroThirdInputRank = rankSecondPair[`RANK_LO_MSB:`RANK_LO_LSB];
    assign loopZeroFourthInputRank = rankSecondPair[`RANK_HI_MSB:`RANK_HI_LSB];

    wire [11:0] rankVector = {loopZeroFourthInputRank, loopZeroThirdInputRank,
        loopZeroSecondInputRank, loopZeroFirstInputRank};

    logic [3:0] eligible;
    logic anyEligible;
    logic [1:0] bestIdx;
    logic [2:0] bestRank;

    ref_rank_finder #(.REFS(4)) u_finder (
        .ranks(rankVector),
        .available(refAvailable),
        .eligible(eligible),
        .anyEligible(anyEligible),
        .bestIdx(bestIdx),
        .bestRank(bestRank)
    );

    wire autoMode = (loopZeroOperatingMode == `MODE_AUTO);
    wire forcedMode = (loopZeroOperatingMode == `MODE_FORCED);
    wire [2:0] currentRank = rankVector[selectedRef*3 +: 3];
    wire currentEligible = eligible[selectedRef];
    // stay on the locked, still eligible reference unless something strictly better appears
    wire keepCurrent = loopLocked && currentEligible && (currentRank <= bestRank);
    wire forcedUsable = refAvailable[choiceControl];
    wire refUsable = autoMode ? anyEligible : forcedUsable;

    logic [1:0] next_selectedRef;
    always_comb begin
        next_selectedRef = selectedRef;
        if (forcedMode) begin
            next_selectedRef = choiceControl;
        end else if (autoMode && anyEligible && !keepCurrent) begin
            next_selectedRef = bestIdx;
        end
    end

    loop_mode_fsm u_fsm (
        .clk(clk),
        .sys_rst(sys_rst),
        .mode(loopZeroOperatingMode),
        .refUsable(refUsable),
        .state(loopState)
    );

    assign loopLocked = (loopState == ST_LOCKED);
    assign loopHoldover = (loopState == ST_HOLDOVER);
    assign loopFreerun = (loopState == ST_FREERUN);
    assign extFeedbackEnable = extFb;

    // in automatic mode the select field is status, otherwise the stored control
    wire [1:0] choiceView = autoMode ? selectedRef : choiceControl;
    wire [7:0] modeView = {choiceView, extFb, 3'h0, loopZeroOperatingMode};
    wire [7:0] readMux = hitSecond ? {1'b0, rankSecondPair[6:4], 1'b0, rankSecondPair[2:0]} :
        hitFirst ? {1'b0, rankFirstPair[6:4], 1'b0, rankFirstPair[2:0]} :
        hitMode ? modeView : 8'h00;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            answerFlag <= 1'b0;
            readData <= 32'h0;
            errFlag <= 1'b0;
        end else begin
            answerFlag <= accessFirst;
            if (accessFirst) begin
                readData <= {24'h0, readMux};
                errFlag <= !hitAny;
            end
        end
    end

    assign pready = answerFlag;
    assign prdata = readData;
    assign pslverr = answerFlag && errFlag;

    // reserved bits are not stored, so they always read back as zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rankSecondPair <= `RST_RANK_SECOND_PAIR;
            rankFirstPair <= `RST_RANK_FIRST_PAIR;
        end else if (regWrite && hitSecond) begin
            rankSecondPair <= {1'b0, pwdata[6:4], 1'b0, pwdata[2:0]};
        end else if (regWrite && hitFirst) begin
            rankFirstPair <= {1'b0, pwdata[6:4], 1'b0, pwdata[2:0]};
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            loopZeroOperatingMode <= MODE_RESET[`MODE_MSB:`MODE_LSB];
            choiceControl <= MODE_RESET[`CHOICE_MSB:`CHOICE_LSB];
            extFb <= MODE_RESET[`EXTFB_BIT];
        end else if (regWrite && hitMode) begin
            loopZeroOperatingMode <= pwdata[`MODE_MSB:`MODE_LSB];
            choiceControl <= pwdata[`CHOICE_MSB:`CHOICE_LSB];
            extFb <= pwdata[`EXTFB_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            selectedRef <= 2'h0;
        end else begin
            selectedRef <= next_selectedRef;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_waiting;
        psel && penable && !pready;
    endsequence
    sequence s_none_usable;
        autoMode && !anyEligible;
    endsequence
    sequence s_one_returns;
        autoMode && anyEligible;
    endsequence

    a_apb_wait_state: assert property (s_setup ##1 s_waiting |=> pready)
        else $error("apb answer not given one cycle after access start");

    a_disabled_never_chosen: assert property (
        autoMode && anyEligible |-> rankVector[next_selectedRef*3 +: 3] != `RANK_DISABLED
            && refAvailable[next_selectedRef])
        else $error("automatic choice picked a disabled or failed reference");

    a_revert_to_best: assert property (
        autoMode && anyEligible && loopLocked && currentEligible && currentRank > bestRank
            |=> selectedRef == $past(bestIdx) && loopLocked)
        else $error("no revert to a better ranked reference");

    a_equal_rank_hold: assert property (
        autoMode && keepCurrent |=> selectedRef == $past(selectedRef))
        else $error("switched away from an equally ranked reference");

    a_lowest_rank_six: assert property (
        refAvailable[0] && loopZeroFirstInputRank == `RANK_MAX_LEGAL |-> eligible[0])
        else $error("rank code 110 treated as disabled");

    a_holdover_when_none: assert property (
        autoMode && !anyEligible |=> loopHoldover && selectedRef == $past(selectedRef))
        else $error("automatic mode not in holdover with no usable reference");

    a_freerun_mode: assert property (
        loopZeroOperatingMode == `MODE_FREERUN && !regWrite |=> loopFreerun)
        else $error("freerun mode not reflected in loop state");

    a_forced_ignores_rank: assert property (
        forcedMode |=> selectedRef == $past(choiceControl)
            && loopLocked == $past(refAvailable[choiceControl]))
        else $error("forced lock did not follow the select field");

    a_status_readback: assert property (
        accessFirst && hitMode && autoMode |=> prdata[7:6] == $past(selectedRef))
        else $error("select field did not read back the chosen reference");

    a_rank_field_write: assert property (
        regWrite && hitFirst |=> loopZeroFirstInputRank == $past(pwdata[2:0])
            && loopZeroSecondInputRank == $past(pwdata[6:4]))
        else $error("rank fields not stored from write data");

    // bus answer, error reporting and register fields
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready stood for more than one cycle");

    a_error_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr raised outside an answer cycle");

    a_unmapped_error: assert property (
        accessFirst && !hitAny |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not answered with an error and zero data");

    a_mapped_no_error: assert property (accessFirst && hitAny |=> pready && !pslverr)
        else $error("mapped access answered with an error");

    a_upper_read_zero: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("read data above the low byte not zero");

    a_unmapped_no_write: assert property (
        commit && pwrite && !hitAny |=> $stable(rankFirstPair) && $stable(rankSecondPair)
            && $stable(loopZeroOperatingMode) && $stable(choiceControl) && $stable(extFb))
        else $error("write to an unmapped address changed a register");

    a_second_pair_write: assert property (
        regWrite && hitSecond
            |=> loopZeroThirdInputRank == $past(pwdata[`RANK_LO_MSB:`RANK_LO_LSB])
            && loopZeroFourthInputRank == $past(pwdata[`RANK_HI_MSB:`RANK_HI_LSB]))
        else $error("third and fourth rank fields not stored from write data");

    a_mode_field_write: assert property (
        regWrite && hitMode |=> loopZeroOperatingMode == $past(pwdata[`MODE_MSB:`MODE_LSB])
            && extFeedbackEnable == $past(pwdata[`EXTFB_BIT]))
        else $error("mode register fields not stored from write data");

    a_choice_readback: assert property (
        accessFirst && hitMode && !autoMode
            |=> prdata[`CHOICE_MSB:`CHOICE_LSB] == $past(choiceControl))
        else $error("select field did not read back the stored control");

    // loop state and reference choice
    a_state_one_hot: assert property (
        $onehot({loopLocked, loopHoldover, loopFreerun}))
        else $error("loop state not one-hot");

    a_holdover_mode: assert property (
        loopZeroOperatingMode == `MODE_HOLDOVER |=> loopHoldover && $stable(selectedRef))
        else $error("forced holdover left the loop state or the chosen reference");

    a_forced_holdover: assert property (
        forcedMode && !forcedUsable |=> loopHoldover)
        else $error("forced reference lost but loop not in holdover");

    a_other_modes_hold: assert property (
        !autoMode && !forcedMode |=> $stable(selectedRef))
        else $error("ranks moved the choice outside automatic mode");

    a_auto_locks: assert property (
        autoMode && anyEligible |=> loopLocked)
        else $error("automatic mode left a usable reference unused");

    a_auto_best_rank: assert property (
        autoMode && anyEligible |-> rankVector[next_selectedRef*3 +: 3] == bestRank)
        else $error("automatic choice not of the best available rank");

    a_fail_forces_switch: assert property (
        autoMode && loopLocked && !currentEligible && anyEligible
            |=> selectedRef == $past(bestIdx))
        else $error("failed reference kept although another was usable");

    a_leave_holdover: assert property (
        s_none_usable ##1 s_one_returns |=> loopLocked && selectedRef == $past(bestIdx))
        else $error("recovery from holdover did not pick the best reference");

    a_rank_six_loses: assert property (
        autoMode && eligible[0] && eligible[1] && loopZeroFirstInputRank == `RANK_MAX_LEGAL
            && loopZeroSecondInputRank < `RANK_MAX_LEGAL |-> next_selectedRef != 2'h0)
        else $error("rank code 110 not ranked below a better enabled reference");
endmodule

// file: tb/dpll_reference_priority_select_tb_top.sv
// self-checking bench for the loop zero reference selector
module dpll_reference_priority_select_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import loop_select_pkg::*;

    logic clk = 1'b0;
    logic sys_rst, psel, penable, pwrite, pready, pslverr, rdErr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdData;
    logic [3:0] refAvailable;
    logic [1:0] selectedRef;
    logic loopLocked, loopHoldover, loopFreerun, extFeedbackEnable;
    int n_fail = 0;
    int tests_run = 0;
    int cycles = 0;

    dpll_reference_priority_select u_dpll_reference_priority_select (
        .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .refAvailable(refAvailable), .selectedRef(selectedRef),
        .loopLocked(loopLocked), .loopHoldover(loopHoldover), .loopFreerun(loopFreerun),
        .extFeedbackEnable(extFeedbackEnable)
    );

    always #25 clk = ~clk;

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // the whole sequence needs about 150 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail = n_fail + 1;
            close_out();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run = tests_run + 1;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            n_fail = n_fail + 1;
        end
    endtask

    // pready and read data are taken at the rising edge that samples them; a hang
    // is ended by the cycle ceiling only
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("prdata", e, rdData);
    endtask

    // expected is {locked, holdover, freerun, selected index}
    task automatic refs(input logic [3:0] v, input logic [4:0] e);
        @(posedge clk);
        refAvailable <= v;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("loop", {27'h0, e}, {27'h0, loopLocked, loopHoldover, loopFreerun, selectedRef});
    endtask

    initial begin
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        refAvailable = 4'hF;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        rd(12'h0C4, 32'h32);
        rd(12'h0C8, 32'h10);
        rd(12'h0CC, 32'h03);
        apb(1'b1, 12'h100, 32'hFF);
        chk("pslverr", 32'h1, {31'h0, rdErr});
        rd(12'h100, 32'h0);
        $display("test reset and map done");
        refs(4'hE, 5'b10001);
        refs(4'hF, 5'b10000);
        refs(4'hC, 5'b10010);
        rd(12'h0CC, 32'h83);
        $display("test revertive done");
        apb(1'b1, 12'h0C8, 32'h07);
        refs(4'hF, 5'b10001);
        apb(1'b1, 12'h0C8, 32'h11);
        apb(1'b1, 12'h0C4, 32'h77);
        refs(4'hD, 5'b10000);
        refs(4'hF, 5'b10000);
        apb(1'b1, 12'h0C4, 32'hF8);
        rd(12'h0C4, 32'h70);
        refs(4'hF, 5'b10010);
        $display("test equal ranks done");
        apb(1'b1, 12'h0C8, 32'h76);
        apb(1'b1, 12'h0C4, 32'h75);
        refs(4'hF, 5'b10010);
        refs(4'hB, 5'b10000);
        refs(4'hA, 5'b01000);
        $display("test lowest rank done");
        apb(1'b1, 12'h0CC, 32'h80);
        refs(4'hF, 5'b00100);
        apb(1'b1, 12'h0CC, 32'h01);
        refs(4'hF, 5'b01000);
        apb(1'b1, 12'h0C4, 32'h77);
        apb(1'b1, 12'h0CC, 32'h82);
        refs(4'hF, 5'b10010);
        refs(4'hB, 5'b01010);
        apb(1'b1, 12'h0CC, 32'h23);
        refs(4'hF, 5'b10000);
        rd(12'h0CC, 32'h23);
        chk("extfb", 32'h1, {31'h0, extFeedbackEnable});
        $display("test modes done");
        close_out();
    end
endmodule
